// ---- src/flash_self_write_pkg.sv ----
// Package of constants and types for the flash self-write controller.
package flash_self_write_pkg;
   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int ROW_WORDS = 32; // Instructions per row.
   localparam int ROW_BYTES = 96; // Bytes per row.
   localparam int PANEL_ROWS = 128; // Rows per panel.
   localparam int LATCH_IDX_W = 5; // Bits selecting a latch word.
   localparam int WORD_W = 24; // Program word width.
   localparam int ADDR_W = 24; // Program address width.
   // ------------------------------------------------------------
   // Address fields
   // ------------------------------------------------------------
   localparam int PAGE_LSB = 0; // Table page bits used.
   localparam int PAGE_MSB = 7;
   localparam int LOW_MSB = 15; // Low part of a program word.
   localparam int HIGH_LSB = 16; // High part of a program word.
   localparam int HIGH_MSB = 23;
   localparam int IDX_LSB = 1; // Word index sits above the byte bit.
   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int CTL_START_BIT = 15; // Start bit.
   localparam int CTL_WRITE_EN_BIT = 14; // Write enable.
   localparam int CTL_ERR_BIT = 13; // Write error flag.
   localparam logic [6:0] OP_ROW_ERASE = 7'h41; // Row erase selection.
   localparam logic [6:0] OP_ROW_PROG = 7'h01; // Row program selection.
   localparam logic [15:0] CTL_RESET = 16'h0000; // Control reset value.
   // ------------------------------------------------------------
   // Key values
   // ------------------------------------------------------------
   localparam logic [7:0] KEY_FIRST = 8'h55; // First unlock value.
   localparam logic [7:0] KEY_SECOND = 8'hAA; // Second unlock value.
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 200; // Core clock rate.
   localparam int OP_TIME_US = 2000; // Nominal operation time, 2 ms.
   localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ; // Cycles per operation.
   localparam int TABLE_WR_CYCLES = 2; // Table write length in cycles.
   typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} key_state_e; // Unlock states.
endpackage

// ---- src/latch_bus_if.sv ----
// Interface carrying latch writes and the latch row contents between the modules.
`timescale 1ns/100ps
interface latch_bus_if;
   import flash_self_write_pkg::*;
   logic wr_low; // Write low part of a latch word.
   logic wr_high; // Write high part of a latch word.
   logic [LATCH_IDX_W-1:0] idx; // Latch word index.
   logic [15:0] data; // Write data.
   logic [1:0] be; // Byte enables of the data.
   logic [ROW_WORDS*WORD_W-1:0] row; // Whole latch row contents.
   modport src (output wr_low, wr_high, idx, data, be, input row);
   modport sink (input wr_low, wr_high, idx, data, be, output row);
endinterface

// ---- src/write_latches.sv ----
// Panel write latches holding one row of program words.
`timescale 1ns/100ps
module write_latches
   import flash_self_write_pkg::*;
(
   input wire logic CORE_CLK, // Core clock.
   input wire logic RESET, // Asynchronous reset, active high.
   latch_bus_if.sink lb // Latch write port.
);
   logic [WORD_W-1:0] word_reg [ROW_WORDS]; // Latch storage.
   // ------------------------------------------------------------
   // Storage, one process per word
   // ------------------------------------------------------------
   for (genvar g = 0; g < ROW_WORDS; g++) begin : g_word
      // Low writes reach bits 15..0, high writes bits 23..16 and use the low byte only.
      always_ff @(posedge CORE_CLK or posedge RESET) begin
         if (RESET) begin
            word_reg[g] <= '0;
         end else if (lb.idx == LATCH_IDX_W'(g)) begin
            if (lb.wr_low && lb.be[0]) begin
               word_reg[g][7:0] <= lb.data[7:0];
            end
            if (lb.wr_low && lb.be[1]) begin
               word_reg[g][LOW_MSB:8] <= lb.data[15:8];
            end
            if (lb.wr_high) begin
               word_reg[g][HIGH_MSB:HIGH_LSB] <= lb.data[7:0];
            end
         end
      end
      assign lb.row[g*WORD_W +: WORD_W] = word_reg[g];
   end
endmodule

// ---- src/op_timer.sv ----
// Operation timer counting the length of one erase or program cycle.
`timescale 1ns/100ps
module op_timer
   import flash_self_write_pkg::*;
#(
   parameter int CYCLES = OP_CYCLES // Cycles per operation.
) (
   input wire logic CORE_CLK, // Core clock.
   input wire logic RESET, // Asynchronous reset, active high.
   input wire logic start, // One-cycle start pulse.
   output logic done // One-cycle pulse at the end.
);
   logic [31:0] count_reg; // Remaining cycles.
   logic busy_reg; // Timer running.
   // ------------------------------------------------------------
   // Countdown
   // ------------------------------------------------------------
   // Counts the operation from start down to one, then pulses done.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         count_reg <= '0;
         busy_reg <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy_reg) begin
            count_reg <= 32'(CYCLES);
            busy_reg <= 1'b1;
         end else if (busy_reg) begin
            if (count_reg <= 32'h0000_0001) begin
               busy_reg <= 1'b0;
               done <= 1'b1;
            end else begin
               count_reg <= count_reg - 32'h0000_0001;
            end
         end
      end
   end
endmodule

// ---- src/flash_self_write.sv ----
// Run-time self-programming controller for the on-chip program flash.
`timescale 1ns/100ps
module flash_self_write
   import flash_self_write_pkg::*;
#(
   parameter int OP_CYCLES_P = OP_CYCLES // Operation length, shorten in simulation.
) (
   input wire logic CORE_CLK, // Core clock, 200 MHz.
   input wire logic RESET, // Asynchronous reset, active high.
   input wire logic TBL_WR_LOW, // Low-part table write strobe.
   input wire logic TBL_WR_HIGH, // High-part table write strobe.
   input wire logic TBL_RD, // Table read strobe, captures address.
   input wire logic TBL_BYTE, // Byte mode access.
   input wire logic [15:0] TBL_OFFSET, // Effective address from working register.
   input wire logic [15:0] TBL_DATA, // Table write source data.
   input wire logic PAGE_WR, // Table page register write.
   input wire logic [15:0] PAGE_DATA, // Table page write data.
   input wire logic CTL_WR, // Control register write.
   input wire logic CTL_SET_START, // Bit-set of the start bit.
   input wire logic [15:0] CTL_DATA, // Control write data.
   input wire logic ADRL_WR, // Low address register write.
   input wire logic ADRH_WR, // High address register write.
   input wire logic KEY_WR, // Unlock key register write.
   input wire logic [15:0] REG_DATA, // Data for address and key writes.
   input wire logic DONE_FLAG_CLR, // Clears the done flag.
   input wire logic ABORT_RESET, // Master or watchdog reset request.
   output logic [15:0] CTL_RD, // Control register readback.
   output logic [15:0] ADRL_RD, // Low address readback.
   output logic [7:0] ADRH_RD, // High address readback.
   output logic [7:0] PAGE_RD, // Table page readback.
   output logic CORE_STALL, // Core stalls while high.
   output logic DONE_FLAG, // Sticky completion flag.
   output logic ARRAY_ERASE, // Row erase pulse to the array.
   output logic ARRAY_PROG, // Row program pulse to the array.
   output logic [ADDR_W-1:0] ARRAY_ADDR, // Row address for the array.
   output logic [ROW_WORDS*WORD_W-1:0] ARRAY_DATA // Row data for programming.
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   latch_bus_if lb (); // Link to the write latches.
   key_state_e key_reg; // Unlock sequence state.
   logic [7:0] page_reg; // Table page register.
   logic [15:0] adrl_reg; // Low address register.
   logic [7:0] adrh_reg; // High address register.
   logic start_reg; // Start bit.
   logic write_en_reg; // Write enable bit.
   logic err_reg; // Write error flag.
   logic [6:0] op_reg; // Operation selection.
   logic tw_busy_reg; // Second cycle of a table write.
   logic op_start; // Launch condition.
   logic op_done; // End of operation.
   logic [ADDR_W-1:0] tbl_addr; // Full table address.
   assign tbl_addr = {page_reg, TBL_OFFSET};
   // A launch needs the start request, the key pair just before, and write enable.
   assign op_start = CTL_SET_START && !start_reg && key_reg == KEY_ARMED
                     && write_en_reg;
   // ------------------------------------------------------------
   // Latch write path
   // ------------------------------------------------------------
   // Word index from the address; rows are 32-word aligned.
   assign lb.idx = tbl_addr[IDX_LSB +: LATCH_IDX_W];
   assign lb.wr_low = TBL_WR_LOW && !start_reg;
   assign lb.wr_high = TBL_WR_HIGH && !start_reg;
   // Byte mode: an odd offset steers the low source byte onto bits 15..8.
   assign lb.data = TBL_BYTE && TBL_OFFSET[0] ? {TBL_DATA[7:0], TBL_DATA[7:0]} : TBL_DATA;
   assign lb.be = TBL_BYTE ? (TBL_OFFSET[0] ? 2'b10 : 2'b01) : 2'b11;
   write_latches u_latches (
      .CORE_CLK(CORE_CLK),
      .RESET(RESET),
      .lb(lb)
   );
   op_timer #(.CYCLES(OP_CYCLES_P)) u_timer (
      .CORE_CLK(CORE_CLK),
      .RESET(RESET),
      .start(op_start),
      .done(op_done)
   );
   // ------------------------------------------------------------
   // Table page register
   // ------------------------------------------------------------
   // Holds the upper address byte for table accesses.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         page_reg <= '0;
      end else if (PAGE_WR) begin
         page_reg <= PAGE_DATA[PAGE_MSB:PAGE_LSB];
      end
   end
   // ------------------------------------------------------------
   // Address registers
   // ------------------------------------------------------------
   // Direct writes win; otherwise a table access captures its address.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         adrl_reg <= '0;
         adrh_reg <= '0;
      end else begin
         if (ADRL_WR) begin
            adrl_reg <= REG_DATA;
         end else if ((TBL_WR_LOW || TBL_WR_HIGH || TBL_RD) && !start_reg) begin
            adrl_reg <= tbl_addr[LOW_MSB:0];
         end
         if (ADRH_WR) begin
            adrh_reg <= REG_DATA[7:0];
         end else if ((TBL_WR_LOW || TBL_WR_HIGH || TBL_RD) && !start_reg) begin
            adrh_reg <= tbl_addr[HIGH_MSB:HIGH_LSB];
         end
      end
   end
   // ------------------------------------------------------------
   // Unlock key sequence
   // ------------------------------------------------------------
   // Arms only after 0x55 then 0xAA; any other key write or a start disarms.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         key_reg <= KEY_IDLE;
      end else if (CTL_SET_START) begin
         key_reg <= KEY_IDLE;
      end else if (KEY_WR) begin
         unique case (key_reg)
            KEY_IDLE, KEY_ARMED: begin
               key_reg <= REG_DATA[7:0] == KEY_FIRST ? KEY_HALF : KEY_IDLE;
            end
            KEY_HALF: begin
               key_reg <= REG_DATA[7:0] == KEY_SECOND ? KEY_ARMED
                          : (REG_DATA[7:0] == KEY_FIRST ? KEY_HALF : KEY_IDLE);
            end
         endcase
      end
   end
   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   // Software writes may set but never clear the start bit; hardware clears it.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         start_reg <= CTL_RESET[CTL_START_BIT];
         write_en_reg <= CTL_RESET[CTL_WRITE_EN_BIT];
         op_reg <= CTL_RESET[6:0];
      end else begin
         if (op_start) begin
            start_reg <= 1'b1;
         end else if (op_done) begin
            start_reg <= 1'b0;
         end
         if (CTL_WR && !start_reg) begin
            write_en_reg <= CTL_DATA[CTL_WRITE_EN_BIT];
            op_reg <= CTL_DATA[6:0];
         end
      end
   end
   // ------------------------------------------------------------
   // Error flag
   // ------------------------------------------------------------
   // Set if a master or watchdog reset cuts an operation short.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         err_reg <= 1'b0;
      end else if (ABORT_RESET && start_reg) begin
         err_reg <= 1'b1;
      end else if (CTL_WR && !start_reg) begin
         err_reg <= CTL_DATA[CTL_ERR_BIT];
      end
   end
   // ------------------------------------------------------------
   // Operation to the array
   // ------------------------------------------------------------
   // Latch contents reach the array only with a launched operation.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         ARRAY_ERASE <= 1'b0;
         ARRAY_PROG <= 1'b0;
         ARRAY_ADDR <= '0;
         ARRAY_DATA <= '0;
      end else begin
         ARRAY_ERASE <= op_start && op_reg == OP_ROW_ERASE;
         ARRAY_PROG <= op_start && op_reg == OP_ROW_PROG;
         if (op_start) begin
            ARRAY_ADDR <= {adrh_reg, adrl_reg[LOW_MSB:IDX_LSB+LATCH_IDX_W],
                           (IDX_LSB+LATCH_IDX_W)'(0)};
            ARRAY_DATA <= lb.row;
         end
      end
   end
   // ------------------------------------------------------------
   // Stall, flag and readback
   // ------------------------------------------------------------
   // Stall covers the operation and the second cycle of each table write.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         tw_busy_reg <= 1'b0;
         CORE_STALL <= 1'b0;
      end else begin
         tw_busy_reg <= (TBL_WR_LOW || TBL_WR_HIGH) && !tw_busy_reg;
         CORE_STALL <= op_start || (start_reg && !op_done)
                       || ((TBL_WR_LOW || TBL_WR_HIGH) && !tw_busy_reg);
      end
   end
   // Done flag: set wins over clear.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         DONE_FLAG <= 1'b0;
      end else if (op_done) begin
         DONE_FLAG <= 1'b1;
      end else if (DONE_FLAG_CLR) begin
         DONE_FLAG <= 1'b0;
      end
   end
   // Registered readback; key register reads nothing.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         CTL_RD <= CTL_RESET;
         ADRL_RD <= '0;
         ADRH_RD <= '0;
         PAGE_RD <= '0;
      end else begin
         CTL_RD <= {start_reg, write_en_reg, err_reg, 6'h00, op_reg};
         ADRL_RD <= adrl_reg;
         ADRH_RD <= adrh_reg;
         PAGE_RD <= page_reg;
      end
   end
endmodule

// ---- sim/flash_self_write_assertions.sv ----
// Port-level assertions for the flash self-write controller.
`timescale 1ns/100ps
module flash_self_write_assertions
   import flash_self_write_pkg::*;
#(
   parameter int OP_CYCLES_P = OP_CYCLES // Operation length.
) (
   input wire logic CORE_CLK, // Clock.
   input wire logic RESET, // Reset.
   input wire logic TBL_WR_LOW, // Low write.
   input wire logic TBL_WR_HIGH, // High write.
   input wire logic PAGE_WR, // Page write.
   input wire logic [15:0] PAGE_DATA, // Page data.
   input wire logic CTL_SET_START, // Start request.
   input wire logic KEY_WR, // Key write.
   input wire logic [15:0] REG_DATA, // Key data.
   input wire logic DONE_FLAG_CLR, // Flag clear.
   input wire logic ABORT_RESET, // Abort.
   input wire logic [15:0] CTL_RD, // Control.
   input wire logic [15:0] ADRL_RD, // Low address.
   input wire logic [7:0] ADRH_RD, // High address.
   input wire logic [7:0] PAGE_RD, // Page.
   input wire logic CORE_STALL, // Stall.
   input wire logic DONE_FLAG, // Done flag.
   input wire logic ARRAY_ERASE, // Erase pulse.
   input wire logic ARRAY_PROG, // Program pulse.
   input wire logic [ADDR_W-1:0] ARRAY_ADDR // Row address.
);
   logic key1_reg, armed_reg, abort_reg; // Unlock progress and abort history.
   int run_reg; // Consecutive stall cycles.
   logic go; // A start that the key pair and write enable allow.
   assign go = CTL_SET_START && armed_reg && CTL_RD[14];
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   // Follows the unlock pair from the inputs alone; any start request disarms.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         key1_reg <= 1'b0;
         armed_reg <= 1'b0;
         abort_reg <= 1'b0;
      end else begin
         abort_reg <= abort_reg | ABORT_RESET;
         if (CTL_SET_START) begin
            key1_reg <= 1'b0;
            armed_reg <= 1'b0;
         end else if (KEY_WR) begin
            key1_reg <= (REG_DATA[7:0] == KEY_FIRST);
            armed_reg <= key1_reg && (REG_DATA[7:0] == KEY_SECOND);
         end
      end
   end
   // Counts how long the stall has stood so far.
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         run_reg <= 0;
      end else begin
         run_reg <= CORE_STALL ? run_reg + 1 : 0;
      end
   end
   property p_stall_len;
      $fell(CORE_STALL) && !abort_reg |-> run_reg == 1 || run_reg == OP_CYCLES_P + 1;
   endproperty
   a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
   property p_done_set; $fell(CTL_RD[15]) && !abort_reg |-> ##[0:1] DONE_FLAG; endproperty
   a_done_set: assert property (p_done_set) else $error("done flag not set");
   property p_done_sticky; DONE_FLAG && !DONE_FLAG_CLR |=> DONE_FLAG; endproperty
   a_done_sticky: assert property (p_done_sticky) else $error("done flag dropped");
   property p_launch_keyed; ARRAY_ERASE || ARRAY_PROG |-> $past(go); endproperty
   a_launch_keyed: assert property (p_launch_keyed) else $error("unkeyed launch");
   property p_keyed_launch;
      go && !CORE_STALL && (CTL_RD[6:0] == OP_ROW_ERASE || CTL_RD[6:0] == OP_ROW_PROG)
         |=> CORE_STALL && (ARRAY_ERASE || ARRAY_PROG);
   endproperty
   a_keyed_launch: assert property (p_keyed_launch) else $error("keyed start lost");
   property p_op_kind;
      ARRAY_ERASE |-> CTL_RD[6:0] == OP_ROW_ERASE && ARRAY_ADDR == {ADRH_RD, ADRL_RD[15:6], 6'h00};
   endproperty
   a_op_kind: assert property (p_op_kind) else $error("erase row wrong");
   property p_tblwr_stall;
      (TBL_WR_LOW || TBL_WR_HIGH) && !CORE_STALL && !CTL_SET_START |=> CORE_STALL ##1 !CORE_STALL;
   endproperty
   a_tblwr_stall: assert property (p_tblwr_stall) else $error("table write length");
   property p_page_rd; PAGE_WR |-> ##2 PAGE_RD == $past(PAGE_DATA[7:0], 2); endproperty
   a_page_rd: assert property (p_page_rd) else $error("page register wrong");
endmodule
bind flash_self_write flash_self_write_assertions #(.OP_CYCLES_P(OP_CYCLES_P)) chk (
   .CORE_CLK(CORE_CLK), .RESET(RESET), .TBL_WR_LOW(TBL_WR_LOW), .TBL_WR_HIGH(TBL_WR_HIGH),
   .PAGE_WR(PAGE_WR), .PAGE_DATA(PAGE_DATA), .CTL_SET_START(CTL_SET_START), .KEY_WR(KEY_WR),
   .REG_DATA(REG_DATA), .DONE_FLAG_CLR(DONE_FLAG_CLR), .ABORT_RESET(ABORT_RESET),
   .CTL_RD(CTL_RD), .ADRL_RD(ADRL_RD), .ADRH_RD(ADRH_RD), .PAGE_RD(PAGE_RD),
   .CORE_STALL(CORE_STALL), .DONE_FLAG(DONE_FLAG), .ARRAY_ERASE(ARRAY_ERASE),
   .ARRAY_PROG(ARRAY_PROG), .ARRAY_ADDR(ARRAY_ADDR));

// ---- sim/core_model.sv ----
// Core-side model issuing table, register, key and reset requests.
`timescale 1ns/100ps
module core_model (
   input wire logic CORE_CLK, // Core clock.
   input wire logic CORE_STALL, // Core waits while high.
   output logic [10:0] STB, // One strobe per request kind.
   output logic [15:0] OFS, // Table effective address.
   output logic [15:0] DAT // Request data.
);
   initial begin
      STB = 11'h000;
      OFS = 16'h0000;
      DAT = 16'h0000;
   end
   // Waits out a stall, holds one request for one edge, then scrambles the buses.
   // A reset indication (kind 10) does not wait, since it comes from outside the core.
   task automatic req(input int k, input logic [15:0] a, input logic [15:0] d, output bit ok);
      int n;
      n = 0;
      @(posedge CORE_CLK);
      while (CORE_STALL !== 1'b0 && k != 10 && n < 200) begin
         @(posedge CORE_CLK);
         n++;
      end
      ok = (n < 200);
      STB[k] <= 1'b1;
      OFS <= a;
      DAT <= d;
      @(posedge CORE_CLK);
      STB[k] <= 1'b0;
      OFS <= ~a; // Released lines must not keep the last value.
      DAT <= ~d;
   endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the flash self-write controller.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb;
   import flash_self_write_pkg::*;
   localparam int OPC = 20; // Shortened operation length.
   localparam int K_WRL = 0, K_WRH = 1, K_RD = 2, K_PAGE = 3, K_CTL = 4, K_GO = 5;
   localparam int K_ADRL = 6, K_ADRH = 7, K_KEY = 8, K_CLR = 9, K_ABT = 10;
   logic CORE_CLK, RESET, stall, done_flag, erase_p, prog_p, bm; // Clock, reset, flags, byte mode.
   logic [10:0] stb; // Request strobes.
   logic [15:0] ofs, dat, ctl_rd, adrl_rd, a, b, lo, hi; // Buses, readbacks, values.
   logic [7:0] adrh_rd, page_rd, pg; // Readbacks and page under test.
   logic [ADDR_W-1:0] arr_addr, last_addr; // Array address and value at last pulse.
   logic [ROW_WORDS*WORD_W-1:0] arr_data, last_data, exp_row; // Row contents.
   int error_cnt = 0, total_checks = 0, n_erase = 0, n_prog = 0, n_stall = 0;
   int e0, p0, s0;
   bit ok;
   // Key cases: bit 31 launch expected, bit 30 write enable, 25:24 count, keys from 23.
   logic [31:0] cs [6] = '{32'hC255AA00, 32'h41AA0000, 32'h435500AA, 32'h4355AA55,
      32'h0255AA00, 32'hC3AA55AA};
   core_model core (.CORE_CLK(CORE_CLK), .CORE_STALL(stall), .STB(stb), .OFS(ofs), .DAT(dat));
   flash_self_write #(.OP_CYCLES_P(OPC)) dut (
      .CORE_CLK(CORE_CLK), .RESET(RESET), .TBL_WR_LOW(stb[0]), .TBL_WR_HIGH(stb[1]),
      .TBL_RD(stb[2]), .TBL_BYTE(bm), .TBL_OFFSET(ofs), .TBL_DATA(dat), .PAGE_WR(stb[3]),
      .PAGE_DATA(dat), .CTL_WR(stb[4]), .CTL_SET_START(stb[5]), .CTL_DATA(dat),
      .ADRL_WR(stb[6]), .ADRH_WR(stb[7]), .KEY_WR(stb[8]), .REG_DATA(dat),
      .DONE_FLAG_CLR(stb[9]), .ABORT_RESET(stb[10]), .CTL_RD(ctl_rd), .ADRL_RD(adrl_rd),
      .ADRH_RD(adrh_rd), .PAGE_RD(page_rd), .CORE_STALL(stall), .DONE_FLAG(done_flag),
      .ARRAY_ERASE(erase_p), .ARRAY_PROG(prog_p), .ARRAY_ADDR(arr_addr), .ARRAY_DATA(arr_data));
   initial begin
      CORE_CLK = 1'b0;
      forever #2.5 CORE_CLK = ~CORE_CLK;
   end
   // Counts array pulses and stall cycles, keeping what the last pulse carried.
   always @(posedge CORE_CLK) begin
      if (erase_p === 1'b1 || prog_p === 1'b1) begin
         last_addr <= arr_addr;
         last_data <= arr_data;
      end
      n_erase <= n_erase + int'(erase_p === 1'b1);
      n_prog <= n_prog + int'(prog_p === 1'b1);
      n_stall <= n_stall + int'(stall === 1'b1);
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Issues one request through the core model, using a as the table address.
   task automatic rq(input int k, input logic [15:0] d);
      core.req(k, a, d, ok);
      if (!ok) begin
         error_cnt++;
         complete_run();
      end
   endtask
   // Lets the design settle until the stall has dropped, within a bound.
   task automatic quiet();
      int n;
      n = 0;
      repeat (2) @(posedge CORE_CLK);
      while (stall !== 1'b0 && n < 200) begin
         @(posedge CORE_CLK);
         n++;
      end
      repeat (2) @(posedge CORE_CLK);
      if (n >= 200) begin
         error_cnt++;
         complete_run();
      end
   endtask
   task automatic endt(input string nm);
      $display("test %s done, mismatches so far %0d", nm, error_cnt);
   endtask
   task automatic go_keys();
      rq(K_KEY, {8'h00, KEY_FIRST});
      rq(K_KEY, {8'h00, KEY_SECOND});
      rq(K_GO, 16'h0000);
   endtask
   // Runs one keyed operation (kind 0 erase, 1 program) and checks its outcome.
   task automatic op_check(input logic [ADDR_W-1:0] row, input int kind);
      e0 = n_erase;
      p0 = n_prog;
      s0 = n_stall;
      rq(K_CLR, 16'h0000); // The operation itself must set the flag again.
      go_keys();
      quiet();
      `CHK("erase pulses", e0 + int'(kind == 0), n_erase)
      `CHK("program pulses", p0 + kind, n_prog)
      `CHK("stall cycles", s0 + OPC + 1, n_stall)
      `CHK("array address", row, last_addr)
      `CHK("start bit", 1'b0, ctl_rd[15])
      `CHK("done flag", 1'b1, done_flag)
      rq(K_CLR, 16'h0000);
      quiet();
      `CHK("done cleared", 1'b0, done_flag)
   endtask
   initial begin
      RESET = 1'b1;
      bm = 1'b0;
      a = 16'h0000;
      void'($urandom(32'h54402B96));
      repeat (2) @(posedge CORE_CLK);
      RESET <= 1'b0;
      quiet();
      `CHK("control reset", 16'h0000, ctl_rd)
      for (int i = 0; i < 4; i++) begin
         pg = 8'($urandom);
         a = 16'($urandom);
         rq(K_PAGE, {8'($urandom), pg});
         rq((i % 2) ? K_RD : K_WRL, 16'($urandom));
         quiet();
         `CHK("page", pg, page_rd)
         `CHK("address low", a, adrl_rd)
         `CHK("address high", pg, adrh_rd)
      end
      endt("capture");
      a = 16'($urandom);
      pg = 8'($urandom);
      rq(K_CTL, {2'b01, 7'h00, OP_ROW_ERASE});
      rq(K_ADRH, {8'h00, pg});
      rq(K_ADRL, a);
      quiet();
      `CHK("direct high", pg, adrh_rd)
      op_check({pg, a[15:6], 6'h00}, 0);
      endt("erase");
      foreach (cs[i]) begin
         rq(K_CTL, {1'b0, cs[i][30], 7'h00, OP_ROW_ERASE});
         e0 = n_erase;
         for (int j = 0; j < int'(cs[i][25:24]); j++) begin
            rq(K_KEY, {8'h00, cs[i][23 - 8 * j -: 8]});
         end
         rq(K_GO, 16'h0000);
         quiet();
         `CHK("launch taken", e0 + int'(cs[i][31]), n_erase)
         `CHK("control kept", {1'b0, cs[i][30], 7'h00, OP_ROW_ERASE}, ctl_rd)
      end
      endt("unlock");
      pg = 8'($urandom);
      b = {10'($urandom), 6'h00};
      rq(K_PAGE, {8'h00, pg});
      p0 = n_prog;
      for (int w = 0; w < ROW_WORDS; w++) begin
         a = b + 16'(2 * w);
         lo = 16'($urandom);
         hi = 16'($urandom);
         exp_row[24 * w +: 24] = {hi[7:0], lo};
         s0 = n_stall;
         rq(K_WRL, lo);
         rq(K_WRH, hi);
         quiet();
         `CHK("table write stall", s0 + 2, n_stall)
      end
      // A byte-mode low write at an odd offset replaces bits 15..8 of word 1 only.
      bm <= 1'b1;
      a = b + 16'h0003;
      lo = 16'($urandom);
      exp_row[32 +: 8] = lo[7:0];
      rq(K_WRL, lo);
      bm <= 1'b0;
      `CHK("no early program", p0, n_prog)
      rq(K_CTL, {2'b01, 7'h00, OP_ROW_PROG});
      op_check({pg, b[15:6], 6'h00}, 1);
      `CHK("row data", exp_row, last_data)
      endt("program");
      rq(K_CTL, {2'b01, 7'h00, OP_ROW_ERASE});
      quiet();
      a = adrl_rd;
      go_keys();
      repeat (10) @(posedge CORE_CLK);
      rq(K_ABT, 16'h0000);
      quiet();
      `CHK("error flag", 1'b1, ctl_rd[13])
      `CHK("address kept", a, adrl_rd)
      endt("abort");
      complete_run();
   end
endmodule
